// ---- design/rpl_map.svh ----
// constants for the rmii latency and isolate block
`ifndef RPL_MAP_SVH
`define RPL_MAP_SVH
`define RPL_CLK_NS 100
`define RPL_BIT_NS 10
`define RPL_TX_LAT_BITX10 170
`define RPL_CRS_ON_BITX10 185
`define RPL_CRS_OFF_BITX10 270
`define RPL_RX_LAT_BITX10 380
`define RPL_ELASTIC_DEFAULT 2'h1
`define RPL_LOOP_DEAD_US 550
`define RPL_ISO_CLEAR_US 100
`define RPL_RESET_NORMAL_US 500
`define RPL_STRAP_SETTLE 16'h0002
`define RPL_STRAP_NONE 5'h00
`define RPL_ISOLATE_BIT 10
`endif

// ---- design/rpl_pkg.sv ----
// types for the rmii latency and isolate block
package rpl_pkg;
	typedef enum logic [1:0] {
		ST_START = 2'b11,
		ST_HOLD = 2'b00,
		ST_WAIT = 2'b01,
		ST_NORMAL = 2'b10
	} rpl_mode_t;
	typedef logic [3:0] rpl_rxword_t;
endpackage : rpl_pkg

// ---- design/rpl_rmii_phy_latency_isolate.sv ----
// rmii receive and transmit latency, loopback dead time, isolate exit and clock output
// Operation
// - in 100 Mb/s loopback, no receive data during a 550 us dead period.
// - in 10 Mb/s loopback, receive valid rises within 2 us of transmit enable.
// - 10 MHz reference clock (100 ns period); transmit dibit and enable sampled on its rising edge.
// - first transmit bit reaches the line about 17 bit times after capture.
// - carrier-valid first rises about 18.5 bit times after start-of-stream arrives.
// - carrier-valid first falls about 27 bit times after end-of-stream arrives.
// - with elasticity setting 01, receive data and error appear after about 38 bits.
// - carrier-valid is raised without waiting on a register stage, for low latency.
// - carrier-valid toggles each clock while buffered data drains after carrier ends.
// - an extra receive-valid output, clocked, marks valid receive data.
// - clearing the isolate bit returns the device to normal within 100 us.
// - after reset with nonzero address strap, normal mode within 500 us.
// - the clock output is derived from the reference clock input.
`include "rpl_map.svh"

module rpl_rmii_phy_latency_isolate #(
	parameter int CLK_DIV = 2,
	parameter int LOOP_DEAD_CYC = `RPL_LOOP_DEAD_US * 1000 / `RPL_CLK_NS,
	parameter int RESET_NORMAL_CYC = `RPL_RESET_NORMAL_US * 1000 / `RPL_CLK_NS
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic softReset,
	input wire logic isolateBit,
	input wire logic [1:0] elasticity,
	input wire logic loopbackEn,
	input wire logic speed100,
	input wire logic [4:0] phyAddressStrap,
	input wire logic [1:0] txd,
	input wire logic txEn,
	input wire logic [1:0] lineRxDibit,
	input wire logic lineRxValid,
	input wire logic lineRxErr,
	input wire logic lineRxStart,
	input wire logic lineRxEnd,
	output logic [1:0] rxd,
	output logic rxEr,
	output logic rxDv,
	output logic crsDv,
	output logic [1:0] lineTxDibit,
	output logic lineTxEn,
	output logic isolated,
	output logic clockOutQuarterRate
);

	// cycle counts from bit-time latencies, never less than one cycle
	function automatic int cyc_of(input int bitx10);
		int c;
		c = bitx10 * `RPL_BIT_NS / (10 * `RPL_CLK_NS);
		return (c < 1) ? 1 : c;
	endfunction : cyc_of

	localparam int TX_LAT_CYC = cyc_of(`RPL_TX_LAT_BITX10);
	localparam int CRS_ON_CYC = cyc_of(`RPL_CRS_ON_BITX10);
	localparam int CRS_OFF_CYC = cyc_of(`RPL_CRS_OFF_BITX10);
	localparam int RX_LAT_CYC = cyc_of(`RPL_RX_LAT_BITX10);
	localparam int ISO_CLEAR_CYC = `RPL_ISO_CLEAR_US * 1000 / `RPL_CLK_NS;

	// line-side inputs come from the recovered-clock domain, so two flops first
	logic [5:0] lineMeta;
	logic [5:0] lineSync;
	logic [4:0] strapMeta;
	logic [4:0] strapSync;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			lineMeta <= 6'h00;
			lineSync <= 6'h00;
			strapMeta <= 5'h00;
			strapSync <= 5'h00;
		end else begin
			lineMeta <= {lineRxEnd, lineRxStart, lineRxErr, lineRxValid, lineRxDibit};
			lineSync <= lineMeta;
			strapMeta <= phyAddressStrap;
			strapSync <= strapMeta;
		end
	end

	// isolate mode sequencing
	rpl_pkg::rpl_mode_t mode;
	logic [15:0] modeTimer;
	logic isoPrev;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			isoPrev <= 1'b1;
		end else begin
			isoPrev <= isolateBit;
		end
	end

	// the strap is read only after the synchroniser has settled past reset
	always_ff @(posedge clk) begin
		if (!rst_b || softReset) begin
			mode <= rpl_pkg::ST_START;
			modeTimer <= `RPL_STRAP_SETTLE;
		end else begin
			unique case (mode)
				rpl_pkg::ST_START: begin
					if (modeTimer != 16'h0000) begin
						modeTimer <= modeTimer - 16'h0001;
					end else if (strapSync != `RPL_STRAP_NONE) begin
						mode <= rpl_pkg::ST_WAIT;
						// settle and decision edges come out of the budget, so the whole exit fits the limit
						modeTimer <= 16'(RESET_NORMAL_CYC - 4);
					end else begin
						mode <= rpl_pkg::ST_HOLD;
					end
				end
				rpl_pkg::ST_HOLD: begin
					if (isoPrev && !isolateBit) begin
						mode <= rpl_pkg::ST_WAIT;
						// the edge that saw the clear and the exit edge both count against the limit
						modeTimer <= 16'(ISO_CLEAR_CYC - 2);
					end
				end
				rpl_pkg::ST_WAIT: begin
					if (isolateBit) begin
						mode <= rpl_pkg::ST_HOLD;
					end else if (modeTimer == 16'h0000) begin
						mode <= rpl_pkg::ST_NORMAL;
					end else begin
						modeTimer <= modeTimer - 16'h0001;
					end
				end
				rpl_pkg::ST_NORMAL: begin
					if (isolateBit) begin
						mode <= rpl_pkg::ST_HOLD;
					end
				end
			endcase
		end
	end

	assign isolated = (mode != rpl_pkg::ST_NORMAL);

	// loopback dead time restarts whenever 100 Mb/s loopback is entered
	logic loop100Prev;
	logic [15:0] deadCnt;
	logic loop100;

	assign loop100 = loopbackEn && speed100;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			loop100Prev <= 1'b0;
			deadCnt <= 16'h0000;
		end else begin
			loop100Prev <= loop100;
			if (loop100 && !loop100Prev) begin
				deadCnt <= 16'(LOOP_DEAD_CYC);
			end else if (deadCnt != 16'h0000) begin
				deadCnt <= deadCnt - 16'h0001;
			end
		end
	end

	// transmit capture and line delay; loopback keeps the line quiet
	logic txEnPrev;
	logic [2:0] txPipe [TX_LAT_CYC];

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			txEnPrev <= 1'b0;
			for (int i = 0; i < TX_LAT_CYC; i++) begin
				txPipe[i] <= 3'h0;
			end
		end else begin
			txEnPrev <= txEn;
			txPipe[0] <= {txEn, txd};
			for (int i = 1; i < TX_LAT_CYC; i++) begin
				txPipe[i] <= txPipe[i - 1];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			lineTxDibit <= 2'h0;
			lineTxEn <= 1'b0;
		end else if (isolated || loopbackEn) begin
			lineTxDibit <= 2'h0;
			lineTxEn <= 1'b0;
		end else begin
			lineTxDibit <= txPipe[TX_LAT_CYC - 1][1:0];
			lineTxEn <= txPipe[TX_LAT_CYC - 1][2];
		end
	end

	// receive source: line, or transmit data in loopback with framing from enable edges
	rpl_pkg::rpl_rxword_t rxSrc;
	logic startSrc;
	logic endSrc;

	always_comb begin
		if (loopbackEn) begin
			rxSrc = {1'b0, txEn, txd};
			startSrc = txEn && !txEnPrev;
			endSrc = !txEn && txEnPrev;
		end else begin
			rxSrc = lineSync[3:0];
			startSrc = lineSync[4];
			endSrc = lineSync[5];
		end
	end

	// the elasticity setting trims the data latency around its default of 01
	logic [1:0] rxTap;
	rpl_pkg::rpl_rxword_t rxPipe [RX_LAT_CYC + 2];
	logic [CRS_ON_CYC-1:0] onPipe;
	logic [CRS_OFF_CYC-1:0] offPipe;

	assign rxTap = elasticity;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			onPipe <= '0;
			offPipe <= '0;
			for (int i = 0; i < RX_LAT_CYC + 2; i++) begin
				rxPipe[i] <= 4'h0;
			end
		end else begin
			onPipe[0] <= startSrc;
			offPipe[0] <= endSrc;
			rxPipe[0] <= rxSrc;
			for (int i = 1; i < CRS_ON_CYC; i++) begin
				onPipe[i] <= onPipe[i - 1];
			end
			for (int i = 1; i < CRS_OFF_CYC; i++) begin
				offPipe[i] <= offPipe[i - 1];
			end
			for (int i = 1; i < RX_LAT_CYC + 2; i++) begin
				rxPipe[i] <= rxPipe[i - 1];
			end
		end
	end

	// setting 00 is one cycle shorter than default, 10 and 11 add one and two
	rpl_pkg::rpl_rxword_t rxTail;

	always_comb begin
		if (rxTap == 2'h0) begin
			rxTail = rxPipe[(RX_LAT_CYC > 1) ? RX_LAT_CYC - 2 : 0];
		end else if (rxTap == `RPL_ELASTIC_DEFAULT) begin
			rxTail = rxPipe[RX_LAT_CYC - 1];
		end else if (rxTap == 2'h2) begin
			rxTail = rxPipe[RX_LAT_CYC];
		end else begin
			rxTail = rxPipe[RX_LAT_CYC + 1];
		end
	end

	// outputs are muted while isolated or during the loopback dead time
	logic rxGate;

	assign rxGate = !isolated && (deadCnt == 16'h0000);

	logic carrier;
	logic crsToggle;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			carrier <= 1'b0;
		end else if (!rxGate) begin
			carrier <= 1'b0;
		end else if (onPipe[CRS_ON_CYC - 1]) begin
			carrier <= 1'b1;
		end else if (offPipe[CRS_OFF_CYC - 1]) begin
			carrier <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rxd <= 2'h0;
			rxEr <= 1'b0;
			rxDv <= 1'b0;
			crsToggle <= 1'b0;
		end else begin
			rxd <= rxGate ? rxTail[1:0] : 2'h0;
			rxEr <= rxGate && rxTail[3];
			rxDv <= rxGate && rxTail[2];
			crsToggle <= (rxDv && !carrier) ? !crsToggle : 1'b0;
		end
	end

	// raised straight from the start tap, skipping the carrier flop, to save a cycle
	assign crsDv = rxGate && (onPipe[CRS_ON_CYC - 1] || carrier || (rxDv && crsToggle));

	// clock output is a plain divider of the reference clock, so it inherits its jitter
	logic [7:0] divCnt;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			divCnt <= 8'h00;
			clockOutQuarterRate <= 1'b0;
		end else if (divCnt == 8'(CLK_DIV / 2 - 1)) begin
			divCnt <= 8'h00;
			clockOutQuarterRate <= !clockOutQuarterRate;
		end else begin
			divCnt <= divCnt + 8'h01;
		end
	end

endmodule : rpl_rmii_phy_latency_isolate

// ---- dv/rpl_checker.sv ----
// port checker for the rmii latency and isolate block
module rpl_checker #(
	parameter int CLK_DIV = 2,
	parameter int RESET_NORMAL_CYC = 20
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic softReset,
	input wire logic isolateBit,
	input wire logic [1:0] elasticity,
	input wire logic loopbackEn,
	input wire logic speed100,
	input wire logic [4:0] phyAddressStrap,
	input wire logic txEn,
	input wire logic lineRxValid,
	input wire logic lineRxStart,
	input wire logic lineRxEnd,
	input wire logic rxDv,
	input wire logic crsDv,
	input wire logic lineTxEn,
	input wire logic isolated,
	input wire logic clockOutQuarterRate
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LIM = RESET_NORMAL_CYC + 6;
	int cnt;
	wire logic live = !isolated && !loopbackEn;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// edges since reset, frozen past the limit so the exit check fires once
	always_ff @(posedge clk) begin
		if (!rst_b || softReset)
			cnt <= 0;
		else if (cnt <= LIM)
			cnt <= cnt + 1;
	end
	a_tx_latency: assert property (live && $past(live) && $past(live, 2) |-> lineTxEn == $past(txEn, 2))
		else $error("line enable off its capture");
	a_crs_on: assert property (lineRxStart && live |-> ##3 crsDv)
		else $error("carrier valid late");
	a_crs_off: assert property (lineRxEnd && live |-> ##[4:6] !crsDv)
		else $error("carrier valid stuck");
	a_rx_latency: assert property (live && $past(live, 7) && elasticity == 2'h1 |-> rxDv == $past(lineRxValid, 6))
		else $error("receive valid off its latency");
	a_dead_quiet: assert property ($rose(loopbackEn && speed100) |=> (!rxDv && !crsDv)[*8])
		else $error("data during dead time");
	a_loop_valid: assert property (loopbackEn && !speed100 && !isolated && $rose(txEn) |-> ##[1:20] rxDv)
		else $error("loopback valid late");
	a_iso_exit: assert property ($fell(isolateBit) |-> ##[0:1000] (!isolated || isolateBit || softReset))
		else $error("isolate exit late");
	a_reset_exit: assert property (cnt == LIM && !isolateBit |-> isolated == (phyAddressStrap == 5'h00))
		else $error("wrong mode after reset");
	a_clk_out: assert property ($past(rst_b, 2) && CLK_DIV == 2 |-> clockOutQuarterRate != $past(clockOutQuarterRate))
		else $error("clock output stalled");
	c_rx: cover property (rxDv && crsDv);
	c_normal: cover property (!isolated);
	c_loop: cover property (loopbackEn && !speed100 && rxDv);
endmodule : rpl_checker

bind rpl_rmii_phy_latency_isolate rpl_checker #(.CLK_DIV(CLK_DIV), .RESET_NORMAL_CYC(RESET_NORMAL_CYC)) chk (
	.clk(clk), .rst_b(rst_b), .softReset(softReset), .isolateBit(isolateBit), .elasticity(elasticity),
	.loopbackEn(loopbackEn), .speed100(speed100), .phyAddressStrap(phyAddressStrap), .txEn(txEn),
	.lineRxValid(lineRxValid), .lineRxStart(lineRxStart), .lineRxEnd(lineRxEnd), .rxDv(rxDv),
	.crsDv(crsDv), .lineTxEn(lineTxEn), .isolated(isolated), .clockOutQuarterRate(clockOutQuarterRate)
);

// ---- dv/rpl_mac_model.sv ----
// mac side partner: sends one frame of eight dibits on request
module rpl_mac_model (
	input wire logic clk,
	input wire logic send,
	output logic [1:0] txd = 2'h0,
	output logic txEn = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] left = 4'h0;
	// dibits left in the frame
	always_ff @(posedge clk) begin
		if (send)
			left <= 4'h8;
		else if (left != 4'h0)
			left <= left - 4'h1;
	end
	// launch on the rising edge; idle data inverts so a stale dibit never looks valid
	always_ff @(posedge clk) begin
		txEn <= send || left > 4'h1;
		if (send || left > 4'h1)
			txd <= send ? 2'h0 : 2'h1 - left[1:0];
		else
			txd <= ~txd;
	end
endmodule : rpl_mac_model

// ---- dv/rpl_rmii_phy_latency_isolate_test.sv ----
// testbench for the rmii latency and isolate block
module rpl_rmii_phy_latency_isolate_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rst_b = 1'b0, softReset = 1'b0, isolateBit = 1'b0, loopbackEn = 1'b0;
	logic speed100 = 1'b1, send = 1'b0, rxV = 1'b0, rxE = 1'b0, rxS = 1'b0, rxN = 1'b0;
	logic [1:0] rxIn = 2'h0, txd, rxd, lineTxDibit, elastic = 2'h1;
	logic [4:0] strap = 5'h01;
	logic txEn, rxEr, rxDv, crsDv, lineTxEn, isolated, clkOut, pc;
	logic [15:0] acc, txAcc;
	int errCount = 0, numChecks = 0, cyc = 0, dv, er, crs, tx, tg;
	rpl_mac_model mac (.clk(clk), .send(send), .txd(txd), .txEn(txEn));
	rpl_rmii_phy_latency_isolate #(.LOOP_DEAD_CYC(20), .RESET_NORMAL_CYC(20)) uut (
		.clk(clk), .rst_b(rst_b), .softReset(softReset), .isolateBit(isolateBit), .elasticity(elastic),
		.loopbackEn(loopbackEn), .speed100(speed100), .phyAddressStrap(strap), .txd(txd), .txEn(txEn),
		.lineRxDibit(rxIn), .lineRxValid(rxV), .lineRxErr(rxE), .lineRxStart(rxS), .lineRxEnd(rxN),
		.rxd(rxd), .rxEr(rxEr), .rxDv(rxDv), .crsDv(crsDv), .lineTxDibit(lineTxDibit), .lineTxEn(lineTxEn),
		.isolated(isolated), .clockOutQuarterRate(clkOut)
	);
	initial forever #50 clk = ~clk;
	// hang guard: the whole run needs well under this many edges
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			errCount++;
			results;
		end
	end
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		numChecks++;
		if (seen !== exp) begin
			errCount++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic clr;
		{dv, er, crs, tx, tg} = '0;
		acc = '0;
		txAcc = '0;
		pc = clkOut;
	endtask : clr
	// one edge, tallying what the outputs showed before it
	task automatic step;
		@(posedge clk);
		dv += (rxDv === 1'b1);
		er += (rxEr === 1'b1);
		crs += (crsDv === 1'b1);
		tx += (lineTxEn === 1'b1);
		tg += (clkOut !== pc);
		pc = clkOut;
		if (rxDv === 1'b1)
			acc = {acc[13:0], rxd};
		if (lineTxEn === 1'b1)
			txAcc = {txAcc[13:0], lineTxDibit};
	endtask : step
	task automatic frame;
		step;
		send <= 1'b1;
		step;
		send <= 1'b0;
		repeat (18) step;
	endtask : frame
	task automatic t_transmit;
		clr;
		frame;
		chk("line enables", tx, 8);
		chk("line dibits", txAcc, 16'h1b1b);
		chk("clock toggles", tg, 20);
		$display("transmit done");
	endtask : t_transmit
	task automatic t_receive;
		clr;
		step;
		rxS <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			step;
			rxS <= 1'b0;
			rxV <= 1'b1;
			rxIn <= i[1:0];
			rxE <= (i == 5);
		end
		step;
		rxV <= 1'b0;
		rxE <= 1'b0;
		rxN <= 1'b1;
		rxIn <= ~rxIn;
		step;
		rxN <= 1'b0;
		repeat (14) step;
		chk("rx valid", dv, 8);
		chk("rx data", acc, 16'h1b1b);
		chk("rx error", er, 1);
		chk("carrier seen", crs != 0, 1);
		$display("receive done");
	endtask : t_receive
	task automatic t_loop;
		loopbackEn <= 1'b1;
		clr;
		frame;
		chk("dead rx valid", dv, 0);
		repeat (20) step;
		loopbackEn <= 1'b0;
		speed100 <= 1'b0;
		step;
		loopbackEn <= 1'b1;
		clr;
		frame;
		chk("loop rx valid", dv, 8);
		loopbackEn <= 1'b0;
		repeat (10) step;
		speed100 <= 1'b1;
		$display("loopback done");
	endtask : t_loop
	// each elasticity step away from the default moves receive data by one cycle
	task automatic t_elastic;
		int lat;
		for (int s = 0; s < 4; s++) begin
			elastic <= s[1:0];
			step;
			rxV <= 1'b1;
			step;
			rxV <= 1'b0;
			lat = 0;
			while (rxDv !== 1'b1 && lat < 12) begin
				step;
				lat++;
			end
			chk("elastic latency", lat, 16'(5 + s));
			// let the pulse drain before the tap moves, so no stale dibit shows at the new tap
			repeat (8) step;
		end
		elastic <= 2'h1;
		$display("elasticity done");
	endtask : t_elastic
	task automatic t_isolate;
		strap <= 5'h00;
		repeat (3) step;
		softReset <= 1'b1;
		step;
		softReset <= 1'b0;
		clr;
		frame;
		repeat (20) step;
		chk("zero strap isolated", isolated, 1);
		chk("muted line", tx, 0);
		isolateBit <= 1'b1;
		repeat (2) step;
		isolateBit <= 1'b0;
		// the exit launched at the limit's last edge is first seen one edge later
		for (int n = 0; n < 1001 && isolated !== 1'b0; n++)
			step;
		chk("isolate exit", isolated, 0);
		$display("isolate done");
	endtask : t_isolate
	task automatic results;
		$display("checks %0d mismatches %0d", numChecks, errCount);
		if (errCount == 0 && numChecks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results
	initial begin
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		repeat (30) step;
		chk("reset exit", isolated, 0);
		t_transmit;
		t_receive;
		t_loop;
		t_elastic;
		t_isolate;
		results;
	end
endmodule : rpl_rmii_phy_latency_isolate_test
